// ### hdl/point_access_pkg.sv
// package: shared constants and types of the point access engine
// assumes one 50 MHz clock and a register bus of 32-bit words
package point_access_pkg;
    localparam int CLOCK_HZ = 50_000_000;
    localparam int NUM_POINTS = 100;
    localparam int PT_IDX_W = 7;
    localparam int NUM_SOCKETS = 4;
    // modbus function and exception codes, coil constants
    localparam logic [7:0] FC_READ_COILS = 8'h01;
    localparam logic [7:0] FC_READ_REGS = 8'h03;
    localparam logic [7:0] FC_WRITE_COIL = 8'h05;
    localparam logic [7:0] FC_WRITE_REG = 8'h06;
    localparam logic [7:0] FC_FORCE_COILS = 8'h0f;
    localparam logic [7:0] FC_WRITE_REGS = 8'h10;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [15:0] COIL_MAX = 16'hffff;
    localparam logic [15:0] COIL_ROUND = 16'h000f;
    localparam logic [15:0] COIL_HREG_MAX = 16'h1000;
    // error codes shown in a point value
    localparam logic [15:0] BAD_PARAMETER_CODE = 16'h0002;
    localparam logic [15:0] BAD_WRITE_VALUE_CODE = 16'h0003;
    localparam logic [15:0] CHECKSUM_FAIL_CODE = 16'h0006;
    localparam logic [15:0] DEVICE_OFFLINE_CODE = 16'h0007;
    localparam logic [15:0] TIMEOUT_FAIL_CODE = 16'h0008;
    localparam logic [15:0] CANNOT_EXECUTE_CODE = 16'h0009;
    localparam logic [15:0] OTHER_FAIL_CODE = 16'h000a;
    // serial link selections
    localparam logic [2:0] BAUD_2400 = 3'h0;
    localparam logic [2:0] BAUD_4800 = 3'h1;
    localparam logic [2:0] BAUD_9600 = 3'h2;
    localparam logic [2:0] BAUD_19200 = 3'h3;
    localparam logic [2:0] BAUD_38400 = 3'h4;
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_NONE1 = 2'h2;
    localparam logic [1:0] PAR_NONE2 = 2'h3;
    // timing
    localparam int SOCK_IDLE_S = 30;
    localparam int RTU_DEFAULT_S = 2;
    localparam int SUP_MIN_MS = 500;
    localparam int SUP_MAX_MS = 30000;
    localparam int MS_CYCLES = CLOCK_HZ / 1000;
    localparam int SEC_CYCLES = CLOCK_HZ;
    // register map (word aligned byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SUP_ADDR = 8'h08;
    localparam logic [7:0] REG_SUP_TMO = 8'h0c;
    localparam logic [7:0] REG_RTU_CFG = 8'h10;
    localparam logic [7:0] REG_PT_SEL = 8'h14;
    localparam logic [7:0] REG_PT_CFG = 8'h18;
    localparam logic [7:0] REG_PT_VAL = 8'h1c;
    localparam logic [7:0] REG_PT_FS = 8'h20;
    localparam logic [15:0] SUP_TMO_RESET = 16'h01f4;
    localparam logic [7:0] RTU_CFG_RESET = 8'h02;

    typedef struct packed {
        logic [15:0] hreg;
        logic [2:0] port;
        logic fs_en;
    } point_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] qty;
        logic [15:0] data;
        logic broadcast;
        logic from_tcp;
    } slave_req_t;

    typedef struct packed {
        logic valid;
        logic exc;
        logic [7:0] code;
        logic [15:0] data;
    } slave_rsp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] func;
        logic [PT_IDX_W-1:0] point;
        logic [15:0] data;
    } master_req_t;
endpackage : point_access_pkg

// ### hdl/point_store.sv
// point store: value memory with registered read port
// assumes a single writer per cycle, merged by the caller
module point_store
    import point_access_pkg::*;
#(
    parameter int DEPTH = NUM_POINTS,
    parameter int AW = PT_IDX_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : point_store

// ### hdl/point_access_engine.sv
// point access engine: modbus slave requests, rtu master demands, socket supervision
// assumes framing done outside; one clock, requests arrive as single-cycle strobes
module point_access_engine
    import point_access_pkg::*;
#(
    parameter int SOCK_IDLE_CYCLES = SOCK_IDLE_S * SEC_CYCLES,
    parameter int SEC_TICK_CYCLES = SEC_CYCLES,
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire slave_req_t slave_req,
    output slave_rsp_t slave_rsp,
    output master_req_t master_req,
    input wire logic master_done,
    input wire logic master_fail,
    input wire logic [15:0] master_rd_data,
    input wire logic [NUM_SOCKETS-1:0] sock_open,
    input wire logic [NUM_SOCKETS-1:0] sock_activity,
    input wire logic [NUM_SOCKETS-1:0] sock_error,
    input wire logic [31:0] sock_peer_addr [NUM_SOCKETS],
    output logic [NUM_SOCKETS-1:0] sock_close,
    output logic [2:0] rtu_baud_sel,
    output logic [1:0] rtu_parity_sel
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_SCAN = 3'b001, ST_HIT = 3'b011, ST_WAIT = 3'b010,
        ST_FS = 3'b110
    } state_t;

    state_t state_q;
    point_cfg_t cfg_q [NUM_POINTS];
    logic [15:0] fs_val_q [NUM_POINTS];
    logic [PT_IDX_W-1:0] scan_q, hit_q, sel_q, fs_q;
    slave_req_t req_q;
    logic found_q;
    logic [15:0] hreg_w;
    logic [3:0] bit_w;
    logic coil_w, func_ok_w;
    logic [31:0] sup_addr_q;
    logic [15:0] sup_tmo_q;
    logic [7:0] rtu_cfg_q;
    logic [7:0] rtu_tmo_s_w;
    logic enable_q;
    logic [15:0] err_cnt_q;
    logic [31:0] sock_cnt_q [NUM_SOCKETS];
    logic [NUM_SOCKETS-1:0] fs_trig_w;
    logic fs_pend_q;
    logic [31:0] ms_div_q, sec_div_q;
    logic ms_tick, sec_tick;
    logic [7:0] mtmo_q;
    logic st_we, sub_we;
    logic [PT_IDX_W-1:0] st_wa, rd_a;
    logic [15:0] st_wd, st_rd;
    logic bus_hit_q;
    logic st_dem, wr_pend_q;
    logic [PT_IDX_W-1:0] wr_pt_q;
    logic [15:0] wr_val_q;

    ////////////////////////////////////////////////////////////////////
    // request decode
    always_comb begin
        coil_w = (req_q.func == FC_READ_COILS) || (req_q.func == FC_WRITE_COIL) ||
                 (req_q.func == FC_FORCE_COILS);
        // coil register and bit; register numbers are the shared 4X space
        hreg_w = coil_w ? 16'((17'(req_q.addr) + 17'(COIL_ROUND)) >> 4)
                        : req_q.addr;
        bit_w = 4'(req_q.addr - 16'h0001);
        func_ok_w = (req_q.func == FC_READ_COILS) || (req_q.func == FC_READ_REGS) ||
                    (req_q.func == FC_WRITE_COIL) || (req_q.func == FC_WRITE_REG) ||
                    (req_q.func == FC_FORCE_COILS) || (req_q.func == FC_WRITE_REGS);
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            scan_q <= '0;
            hit_q <= '0;
            found_q <= 1'b0;
            fs_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (fs_pend_q) begin
                        fs_q <= '0;
                        state_q <= ST_FS;
                    end else if (slave_req.valid && (!slave_req.from_tcp || enable_q)) begin
                        // unit identifier is not part of the request record
                        req_q <= slave_req;
                        scan_q <= '0;
                        found_q <= 1'b0;
                        state_q <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (!found_q && cfg_q[scan_q].hreg == hreg_w && hreg_w != 16'h0000) begin
                        found_q <= 1'b1;
                        hit_q <= scan_q;
                    end
                    if (scan_q == PT_IDX_W'(NUM_POINTS - 1)) begin
                        state_q <= ST_HIT;
                    end else begin
                        scan_q <= scan_q + 1'b1;
                    end
                end
                ST_HIT: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    state_q <= ST_IDLE;
                end
                ST_FS: begin
                    if (fs_q == PT_IDX_W'(NUM_POINTS - 1)) begin
                        state_q <= ST_IDLE;
                    end else begin
                        fs_q <= fs_q + 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    logic is_write_w, is_bcast_ok_w;
    assign is_write_w = (req_q.func == FC_WRITE_COIL) || (req_q.func == FC_WRITE_REG) ||
                        (req_q.func == FC_FORCE_COILS) || (req_q.func == FC_WRITE_REGS);
    assign is_bcast_ok_w = !req_q.broadcast || is_write_w;

    ////////////////////////////////////////////////////////////////////
    // point value store
    assign rd_a = (state_q == ST_HIT || state_q == ST_WAIT) ? hit_q : sel_q;

    always_comb begin
        st_we = 1'b0;
        st_dem = 1'b0;
        st_wa = hit_q;
        st_wd = 16'h0000;
        if (state_q == ST_FS && cfg_q[fs_q].fs_en) begin
            st_we = 1'b1;
            st_dem = 1'b1;
            st_wa = fs_q;
            st_wd = fs_val_q[fs_q];
        end else if (state_q == ST_WAIT && found_q && func_ok_w && is_write_w &&
                     is_bcast_ok_w) begin
            st_we = 1'b1;
            st_dem = 1'b1;
            st_wa = hit_q;
            if (coil_w) begin
                st_wd = st_rd;
                st_wd[bit_w] = req_q.data[0];
            end else begin
                st_wd = req_q.data;
            end
        end else if (master_done && master_req.valid) begin
            st_we = master_req.func == FC_READ_REGS;
            st_wa = master_req.point;
            st_wd = master_rd_data;
        end else if ((master_fail || mtmo_q == 8'h00) && master_req.valid) begin
            st_we = 1'b1;
            st_wa = master_req.point;
            st_wd = master_fail ? DEVICE_OFFLINE_CODE : TIMEOUT_FAIL_CODE;
        end else if (sub_we) begin
            st_we = 1'b1;
            st_dem = 1'b1;
            st_wa = sel_q;
            st_wd = avs_writedata[15:0];
        end
    end

    point_store #(.DEPTH(NUM_POINTS), .AW(PT_IDX_W)) u_store (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(st_we),
        .wr_addr(st_wa),
        .wr_data(st_wd),
        .rd_addr(rd_a),
        .rd_data(st_rd)
    );

    ////////////////////////////////////////////////////////////////////
    // slave response
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slave_rsp <= '0;
        end else begin
            slave_rsp <= '0;
            if (state_q == ST_WAIT && !req_q.broadcast) begin
                slave_rsp.valid <= 1'b1;
                slave_rsp.code <= req_q.func;
                if (!func_ok_w) begin
                    slave_rsp.exc <= 1'b1;
                    slave_rsp.code <= EXC_ILLEGAL_FUNC;
                end else if (!found_q) begin
                    slave_rsp.exc <= 1'b1;
                    slave_rsp.code <= EXC_ILLEGAL_ADDR;
                end else if (coil_w) begin
                    slave_rsp.data <= {15'h0000, st_rd[bit_w]};
                end else begin
                    slave_rsp.data <= is_write_w ? req_q.data : st_rd;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // rtu master demands and timeout
    assign rtu_tmo_s_w = (rtu_cfg_q[7:5] == 3'h0) ? 8'(RTU_DEFAULT_S) : {5'h00, rtu_cfg_q[7:5]};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            master_req <= '0;
            mtmo_q <= 8'h00;
        end else begin
            if (master_req.valid) begin
                if (master_done || master_fail || mtmo_q == 8'h00) begin
                    master_req.valid <= 1'b0;
                    mtmo_q <= 8'h00;
                end else if (sec_tick) begin
                    // one tick beyond the setting, so the wait is never short
                    mtmo_q <= mtmo_q - 8'h01;
                end
            end else if (wr_pend_q) begin
                master_req.valid <= 1'b1;
                master_req.func <= FC_WRITE_REGS;
                master_req.point <= wr_pt_q;
                master_req.data <= wr_val_q;
                mtmo_q <= rtu_tmo_s_w + 8'h01;
            end else if (state_q == ST_IDLE && cfg_q[sel_q].port != 3'h0 && enable_q) begin
                master_req.valid <= 1'b1;
                master_req.func <= FC_READ_REGS;
                master_req.point <= sel_q;
                mtmo_q <= rtu_tmo_s_w + 8'h01;
            end
        end
    end

    // latest write demand waits here while the link is busy
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_pt_q <= '0;
            wr_val_q <= 16'h0000;
        end else if (st_dem && cfg_q[st_wa].port != 3'h0) begin
            wr_pend_q <= 1'b1;
            wr_pt_q <= st_wa;
            wr_val_q <= st_wd;
        end else if (!master_req.valid) begin
            wr_pend_q <= 1'b0;
        end
    end

    assign rtu_baud_sel = (rtu_cfg_q[2:0] > BAUD_38400) ? BAUD_9600 : rtu_cfg_q[2:0];
    assign rtu_parity_sel = rtu_cfg_q[4:3];

    ////////////////////////////////////////////////////////////////////
    // tick dividers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ms_div_q <= '0;
            sec_div_q <= '0;
        end else begin
            ms_div_q <= ms_tick ? '0 : ms_div_q + 1;
            sec_div_q <= sec_tick ? '0 : sec_div_q + 1;
        end
    end
    assign ms_tick = ms_div_q == 32'(MS_TICK_CYCLES - 1);
    assign sec_tick = sec_div_q == 32'(SEC_TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////
    // socket supervision, one counter per socket
    logic [15:0] sup_ms_w;
    assign sup_ms_w = (sup_tmo_q < 16'(SUP_MIN_MS)) ? 16'(SUP_MIN_MS) :
                      (sup_tmo_q > 16'(SUP_MAX_MS)) ? 16'(SUP_MAX_MS) : sup_tmo_q;

    for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_sock
        logic is_sup;
        assign is_sup = sock_peer_addr[s] == sup_addr_q;
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                sock_cnt_q[s] <= '0;
            end else if (!sock_open[s] || sock_activity[s]) begin
                sock_cnt_q[s] <= '0;
            end else if (is_sup ? ms_tick : 1'b1) begin
                sock_cnt_q[s] <= sock_cnt_q[s] + 1;
            end
        end
        assign sock_close[s] = sock_open[s] && (is_sup ? (sock_cnt_q[s] >= 32'(sup_ms_w))
                                              : (sock_cnt_q[s] >= 32'(SOCK_IDLE_CYCLES)));
        assign fs_trig_w[s] = is_sup && sock_open[s] && (sock_error[s] || sock_close[s]);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fs_pend_q <= 1'b0;
        end else if (|fs_trig_w && enable_q) begin
            fs_pend_q <= 1'b1;
        end else if (state_q == ST_IDLE) begin
            fs_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // avalon register slave, one wait cycle on reads
    assign avs_waitrequest = avs_read && !bus_hit_q;
    assign sub_we = avs_write && avs_address == REG_PT_VAL;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_hit_q <= 1'b0;
        end else begin
            bus_hit_q <= avs_read && !bus_hit_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
            sup_addr_q <= '0;
            sup_tmo_q <= SUP_TMO_RESET;
            rtu_cfg_q <= RTU_CFG_RESET;
            sel_q <= '0;
            for (int i = 0; i < NUM_POINTS; i++) begin
                cfg_q[i] <= '0;
                fs_val_q[i] <= '0;
            end
        end else if (avs_write) begin
            unique case (avs_address)
                REG_CTRL: enable_q <= avs_writedata[0];
                REG_SUP_ADDR: sup_addr_q <= avs_writedata;
                REG_SUP_TMO: sup_tmo_q <= avs_writedata[15:0];
                REG_RTU_CFG: rtu_cfg_q <= avs_writedata[7:0];
                REG_PT_SEL: if (avs_writedata[6:0] < PT_IDX_W'(NUM_POINTS)) begin
                    sel_q <= avs_writedata[6:0];
                end
                REG_PT_CFG: cfg_q[sel_q] <= avs_writedata[19:0];
                REG_PT_FS: fs_val_q[sel_q] <= avs_writedata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            err_cnt_q <= '0;
        end else if (state_q == ST_WAIT && !req_q.broadcast && (!found_q || !func_ok_w)) begin
            err_cnt_q <= err_cnt_q + 16'h0001;
        end
    end

    always_comb begin
        avs_readdata = 32'h0000_0000;
        unique case (avs_address)
            REG_CTRL: avs_readdata = {31'h0000_0000, enable_q};
            REG_STATUS: avs_readdata = {err_cnt_q, 8'h00, master_req.valid, fs_pend_q,
                                        sock_open, 2'b00};
            REG_SUP_ADDR: avs_readdata = sup_addr_q;
            REG_SUP_TMO: avs_readdata = {16'h0000, sup_tmo_q};
            REG_RTU_CFG: avs_readdata = {24'h00_0000, rtu_cfg_q};
            REG_PT_SEL: avs_readdata = {25'h000_0000, sel_q};
            REG_PT_CFG: avs_readdata = {12'h000, cfg_q[sel_q]};
            REG_PT_VAL: avs_readdata = {16'h0000, st_rd};
            REG_PT_FS: avs_readdata = {16'h0000, fs_val_q[sel_q]};
            default: avs_readdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_EXC_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == ST_WAIT && !req_q.broadcast && func_ok_w && !found_q) |=>
        (slave_rsp.valid && slave_rsp.exc && slave_rsp.code == EXC_ILLEGAL_ADDR))
        else $error("unassigned register not answered with exception");
    AST_BCAST_SILENT: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == ST_WAIT && req_q.broadcast) |=> !slave_rsp.valid)
        else $error("broadcast produced a response");
    AST_MASTER_FUNC: assert property (@(posedge clock) disable iff (!rst_n)
        master_req.valid |-> (master_req.func == FC_READ_REGS ||
                              master_req.func == FC_WRITE_REGS))
        else $error("master issued an unsupported function");
    AST_SEQ_LEN: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == ST_IDLE && $past(state_q) == ST_IDLE && !fs_pend_q && slave_req.valid &&
         (!slave_req.from_tcp || enable_q)) |=> (state_q == ST_SCAN && scan_q == '0) ##99
        (state_q == ST_SCAN && scan_q == PT_IDX_W'(NUM_POINTS - 1)) ##1 state_q == ST_HIT)
        else $error("scan did not cover all points");
    AST_FS_START: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(fs_pend_q) |-> ##[0:110] state_q == ST_FS)
        else $error("failsafe sweep not started");
    AST_SUP_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
        sup_ms_w >= 16'(SUP_MIN_MS) && sup_ms_w <= 16'(SUP_MAX_MS))
        else $error("supervised timeout outside range");
    AST_RTU_TMO: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(master_req.valid) |-> mtmo_q == rtu_tmo_s_w + 8'h01 && rtu_tmo_s_w != 8'h00)
        else $error("master timeout not loaded");
    AST_BAUD_LEGAL: assert property (@(posedge clock) disable iff (!rst_n)
        rtu_baud_sel <= BAUD_38400)
        else $error("illegal rate selection");
    AST_COIL_BIT: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == ST_WAIT && coil_w && found_q && !req_q.broadcast &&
         req_q.func == FC_READ_COILS) |=> slave_rsp.data[0] == $past(st_rd[bit_w]))
        else $error("coil read returned wrong bit");
endmodule : point_access_engine

// ### dv/rtu_slave_model.sv
// remote rtu slave: answers each master link demand after a chosen delay
// assumes master_req holds valid until answered
module rtu_slave_model
    import point_access_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire master_req_t master_req,
    input wire logic [3:0] delay,
    output logic master_done,
    output logic [15:0] master_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    logic seen_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            seen_q <= 1'b0;
            master_done <= 1'b0;
            master_rd_data <= 16'h0000;
        end else if (master_req.valid !== 1'b1) begin
            cnt_q <= '0;
            seen_q <= 1'b0;
            master_done <= 1'b0;
            master_rd_data <= ~master_rd_data;
        end else if (!seen_q && cnt_q == delay) begin
            seen_q <= 1'b1;
            master_done <= 1'b1;
            master_rd_data <= 16'h5a5a;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            master_done <= 1'b0;
            master_rd_data <= ~master_rd_data;
        end
    end
endmodule : rtu_slave_model

// ### dv/tb_point_access_engine.sv
// bench of the point access engine: register bus, slave requests, rtu writes
// assumes the rtu slave model on the master link; socket activity held low
module tb_point_access_engine
    import point_access_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, master_done;
    logic [7:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rd, v, rng = 40;
    logic [31:0] peer [NUM_SOCKETS] = '{default: '0};
    slave_req_t slave_req = '0;
    slave_rsp_t slave_rsp, e;
    slave_rsp_t expq[$];
    master_req_t master_req;
    logic [15:0] master_rd_data;
    logic [3:0] delay = 4'h3;
    logic [2:0] baud;
    logic [1:0] par;
    logic [3:0] sopen = '0, serr = '0, sclose;
    int num_errors = 0, checked = 0, i;
    always #10 clock = ~clock;
    point_access_engine #(.SOCK_IDLE_CYCLES(200), .SEC_TICK_CYCLES(50), .MS_TICK_CYCLES(5)) DUT (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .slave_req(slave_req), .slave_rsp(slave_rsp),
        .master_req(master_req), .master_done(master_done), .master_fail(1'b0),
        .master_rd_data(master_rd_data), .sock_open(sopen), .sock_activity(4'h0),
        .sock_error(serr), .sock_peer_addr(peer), .sock_close(sclose), .rtu_baud_sel(baud),
        .rtu_parity_sel(par));
    rtu_slave_model slv (.clock(clock), .rst_n(rst_n), .master_req(master_req), .delay(delay),
        .master_done(master_done), .master_rd_data(master_rd_data));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng & 32'h0000_ffff;
    endfunction : nxt
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        checked++;
        if (s !== x) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge clock iff avs_waitrequest === 1'b0);
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rdr(logic [7:0] a);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clock iff avs_waitrequest === 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : rdr
    task automatic req(logic [7:0] f, logic [15:0] a, logic [15:0] d, slave_rsp_t x,
                       logic b = 1'b0);
        if (!b) expq.push_back(x);
        slave_req <= '{1'b1, f, a, 16'h0001, d, b, 1'b0};
        @(posedge clock);
        slave_req.valid <= 1'b0;
        // waits out the answer before the next request
        for (int k = 0; k < 200 && (b ? k < 110 : expq.size() > 0); k++) @(posedge clock);
        @(posedge clock);
    endtask : req
    task automatic end_of_test();
        num_errors += expq.size();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (slave_rsp.valid === 1'b1) begin
            e = expq.size() > 0 ? expq.pop_front() : '0;
            chk("rsp_code", {slave_rsp.exc, slave_rsp.code}, {e.exc, e.code});
            if (!e.exc) chk("rsp_data", slave_rsp.data, e.data);
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("baud", baud, BAUD_9600);
        rdr(REG_SUP_TMO);
        chk("sup_tmo", rd, 32'h0000_01f4);
        rdr(8'hfc);
        chk("unmapped", rd, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_0001);
        wr(REG_PT_SEL, 32'h0000_0000);
        wr(REG_PT_CFG, 32'h0000_0030);
        v = nxt();
        wr(REG_PT_VAL, v);
        $display("registers done");
        req(FC_READ_REGS, 16'h0003, 16'h0000, '{1'b1, 1'b0, FC_READ_REGS, v[15:0]});
        req(FC_READ_COILS, 16'h0022, 16'h0000, '{1'b1, 1'b0, FC_READ_COILS, {15'h0, v[1]}});
        req(FC_READ_COILS, 16'h0030, 16'h0000, '{1'b1, 1'b0, FC_READ_COILS, {15'h0, v[15]}});
        req(FC_READ_COILS, 16'hffff, 16'h0000, '{1'b1, 1'b1, EXC_ILLEGAL_ADDR, 16'h0});
        req(FC_READ_REGS, 16'h0005, 16'h0000, '{1'b1, 1'b1, EXC_ILLEGAL_ADDR, 16'h0});
        req(8'h02, 16'h0003, 16'h0000, '{1'b1, 1'b1, EXC_ILLEGAL_FUNC, 16'h0});
        v = nxt();
        req(FC_WRITE_REG, 16'h0003, v[15:0], '{1'b1, 1'b0, FC_WRITE_REG, v[15:0]});
        req(FC_READ_REGS, 16'h0003, 16'h0000, '{1'b1, 1'b0, FC_READ_REGS, v[15:0]});
        v = nxt();
        req(FC_WRITE_REG, 16'h0003, v[15:0], '0, 1'b1);
        req(FC_READ_REGS, 16'h0003, 16'h0000, '{1'b1, 1'b0, FC_READ_REGS, v[15:0]});
        $display("slave requests done");
        wr(REG_CTRL, 32'h0000_0000);
        wr(REG_PT_CFG, 32'h0000_0032);
        v = nxt();
        wr(REG_PT_VAL, v);
        for (i = 0; i < 100 && master_req.valid !== 1'b1; i++) @(posedge clock);
        chk("mreq_func", master_req.func, FC_WRITE_REGS);
        chk("mreq_data", master_req.data, v);
        for (i = 0; i < 100 && master_req.valid !== 1'b0; i++) @(posedge clock);
        wr(REG_CTRL, 32'h0000_0001);
        for (i = 0; i < 100 && master_req.valid !== 1'b1; i++) @(posedge clock);
        chk("mreq_rd", master_req.func, FC_READ_REGS);
        wr(REG_RTU_CFG, 32'h0000_001c);
        chk("baud", baud, BAUD_38400);
        chk("parity", par, PAR_NONE2);
        $display("master link done");
        v = nxt();
        wr(REG_PT_FS, v);
        wr(REG_PT_CFG, 32'h0000_0031);
        peer[1] <= 32'h0000_0001;
        sopen <= 4'h2;
        // counted at falling edges: idle limit plus one
        for (i = 0; i < 300 && sclose[1] !== 1'b1; i++) @(negedge clock);
        chk("idle_close", i, 201);
        @(posedge clock);
        rdr(REG_STATUS);
        chk("no_failsafe", rd[6], 1'b0);
        sopen <= 4'h1;
        serr <= 4'h1;
        @(posedge clock);
        serr <= 4'h0;
        repeat (110) @(posedge clock);
        rdr(REG_PT_VAL);
        chk("failsafe", rd, v);
        $display("sockets done");
        end_of_test();
    end
endmodule : tb_point_access_engine
